// ===== dv/cfs_host_model.sv
// Host serial port model that faces the codec front end.
module cfs_host_model (
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic        junk,
  input  wire logic        serial_clock,
  input  wire logic        serial_data_out,
  input  wire logic        output_frame_sync,
  input  wire logic [15:0] tx_word,
  input  wire logic        tx_go,
  output logic             serial_data_in,
  output logic             input_frame_sync,
  output logic             tx_busy,
  output logic      [15:0] rx_word,
  output logic             rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sclk_q = 1'b0;
  logic [4:0]  tcnt   = 5'h0;
  logic [4:0]  rcnt   = 5'h0;
  logic [15:0] tsh;
  logic [15:0] rsh;
  initial
  begin
    serial_data_in   = 1'b0;
    input_frame_sync = 1'b0;
    rx_valid         = 1'b0;
  end
  assign tx_busy = (tcnt != 5'h0);
  // Lines move half a clock after the edge that moves the bit clock.
  always @(negedge clk)
  begin
    sclk_q   <= serial_clock;
    rx_valid <= 1'b0;
    if (junk)
    begin
      serial_data_in   <= ~serial_data_in;
      input_frame_sync <= ~input_frame_sync;
    end
    else if (tcnt == 5'h0)
      input_frame_sync <= 1'b0;
    if (tx_go)
    begin
      tsh  <= tx_word;
      tcnt <= 5'h12;
    end
    else if (serial_clock && !sclk_q && tcnt != 5'h0)
    begin
      input_frame_sync <= (tcnt == 5'h12);
      // A released line shows the inverse of its last bit, so stale data cannot pass.
      serial_data_in   <= (tcnt == 5'h12 || tcnt == 5'h01) ? ~serial_data_in : tsh[15];
      if (tcnt <= 5'h11)
        tsh <= {tsh[14:0], 1'b0};
      tcnt <= tcnt - 5'h01;
    end
    if (!en)
      rcnt <= 5'h0;
    else if (!serial_clock && sclk_q)
    begin
      if (rcnt == 5'h0)
        rcnt <= output_frame_sync ? 5'h10 : 5'h0;
      else
      begin
        rsh      <= {rsh[14:0], serial_data_out};
        rx_word  <= {rsh[14:0], serial_data_out};
        rx_valid <= (rcnt == 5'h01);
        rcnt     <= rcnt - 5'h01;
      end
    end
  end
endmodule : cfs_host_model

// ===== dv/test_cfs_frontend.sv
// Self-checking bench of the codec serial port front end.
module test_cfs_frontend;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MD  = 1;
  localparam int SD  = 8;
  localparam int BIT = MD * SD;
  localparam int SMP = 256 * MD;
  logic        clk, reset_n, port_enable, serial_data_in, input_frame_sync;
  logic        serial_clock, serial_data_out, serial_data_out_oe, sample_tick;
  logic        output_frame_sync, output_frame_sync_oe;
  logic [14:0] adc_sample;
  logic [15:0] dac_sample, tx_word, rx_word, rb_word, dac_exp, w;
  logic [39:0] control_regs, exp_regs;
  logic        junk, tx_go, tx_busy, rx_valid, rb_pending;
  logic        sclk_q, oe_q, ofs_q, d1, d2;
  logic [15:0] q[$];
  logic [31:0] lfsr;
  int          err_total, comparisons, quiet, gap_s, gap_t, run_o, run_f, n;

  cfs_frontend #(.MCLK_DIV(MD), .SCLK_DIV(SD)) cfs_frontend_i (
    .clk, .reset_n, .port_enable, .serial_data_in, .input_frame_sync, .serial_clock,
    .serial_data_out, .serial_data_out_oe, .output_frame_sync, .output_frame_sync_oe,
    .adc_sample, .sample_tick, .dac_sample, .control_regs
  );
  cfs_host_model cfs_host_model_i (
    .clk, .en(port_enable), .junk, .serial_clock, .serial_data_out, .output_frame_sync,
    .tx_word, .tx_go, .serial_data_in, .input_frame_sync, .tx_busy, .rx_word, .rx_valid
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction : lfsr_next
  task automatic tally(input logic bad, input string nm, input string e, input string g);
    comparisons++;
    if (bad)
    begin
      err_total++;
      $display("MISMATCH %s expected %s seen %s", nm, e, g);
    end
  endtask : tally
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    tally(g !== e, nm, $sformatf("%h", e), $sformatf("%h", g));
  endtask : chk_word
  task automatic chk_regs(input string nm, input logic [39:0] e, input logic [39:0] g);
    tally(g !== e, nm, $sformatf("%h", e), $sformatf("%h", g));
  endtask : chk_regs
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tally(g !== e, nm, $sformatf("%b", e), $sformatf("%b", g));
  endtask : chk_bit
  task automatic chk_cnt(input string nm, input int e, input int g);
    tally(g != e, nm, $sformatf("%0d", e), $sformatf("%0d", g));
  endtask : chk_cnt
  task automatic end_of_test;
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // Words go out right after a tick so that each finishes before the next one.
  task automatic send(input logic [15:0] word);
    @(negedge clk iff sample_tick);
    tx_word <= word;
    tx_go   <= 1'b1;
    @(negedge clk);
    tx_go <= 1'b0;
    @(negedge clk);
    for (int i = 0; i < 400 && tx_busy; i++)
      @(negedge clk);
    repeat (8) @(negedge clk);
  endtask : send
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk_regs("regs in reset", 40'h00_0000_0000, control_regs);
    chk_word("sample in reset", 16'h0000, dac_sample);
    chk_bit("drive in reset", 1'b0, serial_data_out_oe);
    reset_n  <= 1'b1;
    exp_regs = 40'h00_0000_0000;
    dac_exp  = 16'h0000;
    q.delete();
  endtask : do_reset

  initial
  begin
    // master clock from the host side
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  always @(negedge clk)
  begin
    lfsr       <= lfsr_next(lfsr);
    adc_sample <= lfsr[14:0];
  end
  // Expected words are noted at the tick that loads them; the receiver takes the oldest.
  always @(posedge clk)
  begin
    if (reset_n && sample_tick)
    begin
      q.push_back(rb_pending ? rb_word : {1'b0, adc_sample});
      rb_pending = 1'b0;
    end
    if (quiet > 300)
    begin
      if (serial_clock && !sclk_q)
        chk_cnt("bit period", BIT, gap_s);
      if (!serial_data_out_oe && oe_q)
        chk_cnt("drive span", 16 * BIT, run_o);
      if (!output_frame_sync && ofs_q)
        chk_bit("drive after sync", 1'b1, serial_data_out_oe);
      if (!output_frame_sync && ofs_q)
        chk_cnt("sync width", BIT, run_f);
      if (sample_tick)
        chk_cnt("sample period", SMP, gap_t);
    end
    if (rx_valid && q.size() == 0)
      chk_cnt("words noted", 1, 0);
    else if (rx_valid)
      chk_word("sent word", q.pop_front(), rx_word);
    if (d2 && reset_n)
      chk_word("output sample", dac_exp, dac_sample);
    quiet = (reset_n && port_enable) ? quiet + 1 : 0;
    gap_s = (serial_clock && !sclk_q) ? 1 : gap_s + 1;
    gap_t = sample_tick ? 1 : gap_t + 1;
    run_o = serial_data_out_oe ? run_o + 1 : 0;
    run_f = output_frame_sync ? run_f + 1 : 0;
    sclk_q = serial_clock;
    oe_q   = serial_data_out_oe;
    ofs_q  = output_frame_sync;
    d2     = d1;
    d1     = sample_tick;
  end

  initial
  begin
    {reset_n, junk, tx_go, rb_pending, sclk_q, oe_q, ofs_q, d1, d2} = 9'h000;
    port_enable = 1'b1;
    tx_word     = 16'h0000;
    lfsr        = 32'h6717_b0b4;
    adc_sample  = 15'h0000;
    do_reset();
    for (int i = 0; i < 8; i++)
    begin
      w = {8'h80 | 8'(i), lfsr[7:0]};
      send(w);
      if (i < 5)
        exp_regs[8*i +: 8] = w[7:0];
      chk_regs("control regs", exp_regs, control_regs);
    end
    for (int i = 0; i < 5; i++)
    begin
      send({8'hc0 | 8'(i), 8'h00});
      rb_word    = {8'hc0 | 8'(i), exp_regs[8*i +: 8]};
      rb_pending = 1'b1;
    end
    for (int i = 0; i < 4; i++)
    begin
      w = (i == 0) ? 16'h3fff : (i == 1) ? 16'h4000 : {1'b0, lfsr[14:0]};
      send(w);
      dac_exp = w;
    end
    repeat (3) @(negedge clk iff sample_tick);
    @(negedge clk iff sample_tick);
    port_enable <= 1'b0;
    junk        <= 1'b1;
    repeat (12) @(negedge clk);
    q.delete();
    repeat (400)
    begin
      @(negedge clk);
      chk_bit("data drive", 1'b0, serial_data_out_oe);
      chk_bit("sync drive", 1'b0, output_frame_sync_oe);
      chk_bit("bit clock", 1'b0, serial_clock);
      chk_bit("sample tick", 1'b0, sample_tick);
    end
    junk <= 1'b0;
    @(negedge clk);
    port_enable <= 1'b1;
    for (n = 0; n < 400 && sample_tick !== 1'b1; n++)
      @(negedge clk);
    chk_bit("tick restart", 1'b1, n >= 250 && n <= 262);
    chk_regs("regs kept", exp_regs, control_regs);
    send(16'h1234);
    dac_exp = 16'h1234;
    do_reset();
    send(16'h82a5);
    exp_regs[23:16] = 8'ha5;
    send(16'hc200);
    rb_word    = 16'hc2a5;
    rb_pending = 1'b1;
    @(negedge clk iff sample_tick);
    repeat (200) @(negedge clk);
    chk_cnt("words left", 0, q.size());
    end_of_test();
  end
endmodule : test_cfs_frontend

// ===== verilog/cfs_cfg.svh
// Constants of the codec serial port front end.
`ifndef CFS_CFG_SVH
`define CFS_CFG_SVH
`define CFS_WORD_W      16
`define CFS_FLAG_BIT    15
`define CFS_READ_BIT    14
`define CFS_ADDR_HI     10
`define CFS_ADDR_LO     8
`define CFS_CREG_W      8
`define CFS_NUM_CREG    5
`define CFS_CREG_RST    8'h00
`define CFS_SAMPLE_DIV  256
`define CFS_MCLK_DIV    1
`define CFS_SCLK_DIV    8
`endif

// ===== verilog/cfs_clkdiv.sv
// Device clock tick and serial bit clock divider.
`include "cfs_cfg.svh"
module cfs_clkdiv #(
  parameter int MCLK_DIV = `CFS_MCLK_DIV,
  parameter int SCLK_DIV = `CFS_SCLK_DIV
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic run,
  output logic      dev_tick,
  output logic      sclk,
  output logic      sclk_rise,
  output logic      sclk_fall
);
  localparam int HALF = SCLK_DIV / 2;
  localparam int MW   = $clog2(MCLK_DIV + 1);
  localparam int HW   = $clog2(HALF + 1);
  localparam int HIGH_CLKS = MCLK_DIV * HALF;

  logic [MW-1:0] mcnt;
  logic [MW-1:0] next_mcnt;
  logic          next_dev_tick;
  logic [HW-1:0] hcnt;
  logic [HW-1:0] next_hcnt;
  logic          next_sclk;
  logic          next_sclk_rise;
  logic          next_sclk_fall;
  logic [15:0]   high_len;

  always_comb
  begin
    next_mcnt      = mcnt;
    next_dev_tick  = 1'b0;
    next_hcnt      = hcnt;
    next_sclk      = sclk;
    next_sclk_rise = 1'b0;
    next_sclk_fall = 1'b0;
    if (mcnt == MW'(MCLK_DIV - 1))
    begin
      next_mcnt     = '0;
      next_dev_tick = 1'b1;
    end
    else
    begin
      next_mcnt = mcnt + 1'b1;
    end
    if (!run && !sclk)
    begin
      next_hcnt = '0;
    end
    else if (dev_tick)
    begin
      if (hcnt == HW'(HALF - 1))
      begin
        next_hcnt      = '0;
        next_sclk      = !sclk;
        next_sclk_rise = !sclk;
        next_sclk_fall = sclk;
      end
      else
      begin
        next_hcnt = hcnt + 1'b1;
      end
    end
    if (!reset_n)
    begin
      next_mcnt      = '0;
      next_dev_tick  = 1'b0;
      next_hcnt      = '0;
      next_sclk      = 1'b0;
      next_sclk_rise = 1'b0;
      next_sclk_fall = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    mcnt      <= next_mcnt;
    dev_tick  <= next_dev_tick;
    hcnt      <= next_hcnt;
    sclk      <= next_sclk;
    sclk_rise <= next_sclk_rise;
    sclk_fall <= next_sclk_fall;
  end

  always_ff @(posedge clk)
  begin
    high_len <= (sclk && reset_n) ? high_len + 16'h0001 : 16'h0000;
  end

  AST_SCLK_HIGH_LEN: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(sclk) |-> high_len == 16'(HIGH_CLKS))
    else $error("Bit clock high phase has the wrong length.");
endmodule : cfs_clkdiv

// ===== verilog/cfs_frontend.sv
// Serial port and clocking front end of a voiceband codec.
// Function
// - Low reset clears registers and all logic.
// - Bit clock comes from master clock via both dividers.
// - Output bits change on bit clock rise.
// - Data output floats when idle or disabled.
// - Output sync pulses one bit before MSB.
// - Output sync floats while port disabled.
// - Input sync sampled on falling edge.
// - Input data bits sampled on falling edge.
// - Disabled port ignores data and sync inputs.
// - Disable floats outputs and stops bit clock.
// - Re-enable keeps registers, restarts timing counters.
// - Device clock is divided master clock.
// - Sample rate is device clock over 256.
// - Five eight-bit read/write control registers.
// - Loop-back wiring makes input and output simultaneous.
// - Sixteen-bit words, one control/data flag bit.
// - Samples are two's complement.
// - Missing new sample reuses previous one.
`include "cfs_cfg.svh"
module cfs_frontend #(
  parameter int MCLK_DIV = `CFS_MCLK_DIV,
  parameter int SCLK_DIV = `CFS_SCLK_DIV
) (
  input  wire logic                                clk,
  input  wire logic                                reset_n,
  input  wire logic                                port_enable,
  input  wire logic                                serial_data_in,
  input  wire logic                                input_frame_sync,
  output logic                                     serial_clock,
  output logic                                     serial_data_out,
  output logic                                     serial_data_out_oe,
  output logic                                     output_frame_sync,
  output logic                                     output_frame_sync_oe,
  input  wire logic [`CFS_WORD_W-2:0]              adc_sample,
  output logic                                     sample_tick,
  output logic      [`CFS_WORD_W-1:0]              dac_sample,
  output logic      [`CFS_NUM_CREG*`CFS_CREG_W-1:0] control_regs
);
  import cfs_pkg::*;

  localparam int W   = `CFS_WORD_W;
  localparam int CW  = `CFS_CREG_W;
  localparam int NR  = `CFS_NUM_CREG;
  localparam int SW  = $clog2(`CFS_SAMPLE_DIV);
  localparam int GAP = `CFS_SAMPLE_DIV * MCLK_DIV;

  logic [2:0]          pins_s;
  logic                port_en;
  logic                sdi_s;
  logic                ifs_s;
  logic                dev_tick;
  logic                rise;
  logic                fall;
  logic [SW-1:0]       scnt;
  logic [SW-1:0]       next_scnt;
  logic                next_sample_tick;
  cfs_tx_state_t       tx_state;
  cfs_tx_state_t       next_tx_state;
  logic [3:0]          tx_cnt;
  logic [3:0]          next_tx_cnt;
  logic [W-1:0]        tx_word;
  logic [W-1:0]        next_tx_word;
  logic                tx_pending;
  logic                next_tx_pending;
  logic                next_serial_data_out;
  logic                next_output_frame_sync;
  cfs_rx_state_t       rx_state;
  cfs_rx_state_t       next_rx_state;
  logic [3:0]          rx_cnt;
  logic [3:0]          next_rx_cnt;
  logic [W-1:0]        rx_shift;
  logic [W-1:0]        next_rx_shift;
  logic [W-1:0]        rx_hold;
  logic [W-1:0]        next_rx_hold;
  logic                rx_fresh;
  logic                next_rx_fresh;
  logic [W-1:0]        next_dac_sample;
  logic [NR*CW-1:0]    next_control_regs;
  logic                rb_pending;
  logic                next_rb_pending;
  logic [W-1:0]        rb_word;
  logic [W-1:0]        next_rb_word;
  logic [W-1:0]        rx_word;
  logic [2:0]          rx_addr;
  logic [15:0]         gap_cnt;
  logic                gap_seen;

  function automatic logic addr_ok(input logic [2:0] a);
    addr_ok = (a < 3'(NR));
  endfunction : addr_ok

  cfs_sync #(
    .W(3)
  ) u_sync (
    .clk    (clk),
    .reset_n(reset_n),
    .din    ({port_enable, serial_data_in, input_frame_sync}),
    .dout   (pins_s)
  );
  assign port_en = pins_s[2];
  assign sdi_s   = pins_s[1];
  assign ifs_s   = pins_s[0];

  cfs_clkdiv #(
    .MCLK_DIV(MCLK_DIV),
    .SCLK_DIV(SCLK_DIV)
  ) u_clkdiv (
    .clk      (clk),
    .reset_n  (reset_n),
    .run      (port_en),
    .dev_tick (dev_tick),
    .sclk     (serial_clock),
    .sclk_rise(rise),
    .sclk_fall(fall)
  );

  // float unless a word is shifting
  assign serial_data_out_oe   = port_en && (tx_state == CFS_TX_SHIFT);
  assign output_frame_sync_oe = port_en;
  assign rx_word = {rx_shift[W-2:0], sdi_s};
  assign rx_addr = rx_word[`CFS_ADDR_HI:`CFS_ADDR_LO];

  always_comb
  begin
    next_scnt              = scnt;
    next_sample_tick       = 1'b0;
    next_tx_state          = tx_state;
    next_tx_cnt            = tx_cnt;
    next_tx_word           = tx_word;
    next_tx_pending        = tx_pending;
    next_serial_data_out   = serial_data_out;
    next_output_frame_sync = output_frame_sync;
    next_rx_state          = rx_state;
    next_rx_cnt            = rx_cnt;
    next_rx_shift          = rx_shift;
    next_rx_hold           = rx_hold;
    next_rx_fresh          = rx_fresh;
    next_dac_sample        = dac_sample;
    next_control_regs      = control_regs;
    next_rb_pending        = rb_pending;
    next_rb_word           = rb_word;
    if (dev_tick)
    begin
      next_scnt = scnt + 1'b1;
      if (scnt == SW'(`CFS_SAMPLE_DIV - 1))
      begin
        next_sample_tick = 1'b1;
      end
    end
    if (sample_tick)
    begin
      next_dac_sample = rx_hold;
      next_rx_fresh   = 1'b0;
      next_tx_pending = 1'b1;
      if (rb_pending)
      begin
        next_tx_word    = rb_word;
        next_rb_pending = 1'b0;
      end
      else
      begin
        next_tx_word = {1'b0, adc_sample};
      end
    end
    if (rise)
    begin
      unique case (tx_state)
        CFS_TX_IDLE:
        begin
          if (tx_pending && !sample_tick)
          begin
            next_output_frame_sync = 1'b1;
            next_tx_state          = CFS_TX_FSYNC;
            next_tx_pending        = 1'b0;
          end
        end
        CFS_TX_FSYNC:
        begin
          next_output_frame_sync = 1'b0;
          next_serial_data_out   = tx_word[W-1];
          next_tx_cnt            = '0;
          next_tx_state          = CFS_TX_SHIFT;
        end
        CFS_TX_SHIFT:
        begin
          if (tx_cnt == 4'hf)
          begin
            next_tx_state = CFS_TX_IDLE;
          end
          else
          begin
            next_serial_data_out = tx_word[4'(W - 2) - tx_cnt];
            next_tx_cnt          = tx_cnt + 1'b1;
          end
        end
      endcase
    end
    if (fall)
    begin
      unique case (rx_state)
        CFS_RX_IDLE:
        begin
          // input sync seen on falling edge
          if (ifs_s)
          begin
            next_rx_state = CFS_RX_SHIFT;
            next_rx_cnt   = '0;
          end
        end
        CFS_RX_SHIFT:
        begin
          next_rx_shift = rx_word;
          next_rx_cnt   = rx_cnt + 1'b1;
          if (rx_cnt == 4'hf)
          begin
            next_rx_state = CFS_RX_IDLE;
            if (!rx_word[`CFS_FLAG_BIT])
            begin
              next_rx_hold  = rx_word;
              next_rx_fresh = 1'b1;
            end
            else if (addr_ok(rx_addr) && rx_word[`CFS_READ_BIT])
            begin
              next_rb_pending = 1'b1;
              next_rb_word    = {rx_word[W-1:CW], control_regs[rx_addr*CW +: CW]};
            end
            else if (addr_ok(rx_addr))
            begin
              next_control_regs[rx_addr*CW +: CW] = rx_word[CW-1:0];
            end
          end
        end
      endcase
    end
    if (!port_en)
    begin
      next_scnt              = '0;
      next_sample_tick       = 1'b0;
      next_tx_state          = CFS_TX_IDLE;
      next_tx_cnt            = '0;
      next_tx_pending        = 1'b0;
      next_output_frame_sync = 1'b0;
      next_rx_state          = CFS_RX_IDLE;
      next_rx_cnt            = '0;
      next_rx_fresh          = 1'b0;
    end
    if (!reset_n)
    begin
      next_scnt              = '0;
      next_sample_tick       = 1'b0;
      next_tx_state          = CFS_TX_IDLE;
      next_tx_cnt            = '0;
      next_tx_word           = '0;
      next_tx_pending        = 1'b0;
      next_serial_data_out   = 1'b0;
      next_output_frame_sync = 1'b0;
      next_rx_state          = CFS_RX_IDLE;
      next_rx_cnt            = '0;
      next_rx_shift          = '0;
      next_rx_hold           = '0;
      next_rx_fresh          = 1'b0;
      next_dac_sample        = '0;
      next_control_regs      = {NR{`CFS_CREG_RST}};
      next_rb_pending        = 1'b0;
      next_rb_word           = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    scnt              <= next_scnt;
    sample_tick       <= next_sample_tick;
    tx_state          <= next_tx_state;
    tx_cnt            <= next_tx_cnt;
    tx_word           <= next_tx_word;
    tx_pending        <= next_tx_pending;
    serial_data_out   <= next_serial_data_out;
    output_frame_sync <= next_output_frame_sync;
    rx_state          <= next_rx_state;
    rx_cnt            <= next_rx_cnt;
    rx_shift          <= next_rx_shift;
    rx_hold           <= next_rx_hold;
    rx_fresh          <= next_rx_fresh;
    dac_sample        <= next_dac_sample;
    control_regs      <= next_control_regs;
    rb_pending        <= next_rb_pending;
    rb_word           <= next_rb_word;
  end

  // Helper timing of the gap between sample strobes.
  always_ff @(posedge clk)
  begin
    if (!reset_n || !port_en)
    begin
      gap_cnt  <= 16'h0000;
      gap_seen <= 1'b0;
    end
    else if (sample_tick)
    begin
      gap_cnt  <= 16'h0000;
      gap_seen <= 1'b1;
    end
    else
    begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_sync_bit;
    tx_state == CFS_TX_FSYNC && output_frame_sync && rise;
  endsequence

  sequence s_msb_out;
    tx_state == CFS_TX_SHIFT && !output_frame_sync && serial_data_out == $past(tx_word[W-1]);
  endsequence

  AST_RESET_CLEARS: assert property (disable iff (1'b0)
    !reset_n |=> control_regs == {NR{`CFS_CREG_RST}} && !sample_tick && tx_state == CFS_TX_IDLE)
    else $error("Reset did not clear the block.");

  AST_SYNC_THEN_MSB: assert property (s_sync_bit |=> s_msb_out)
    else $error("Output sync not followed by the MSB.");

  AST_SDO_ON_RISE: assert property (
    port_en && $past(port_en) && $changed(serial_data_out) |-> $past(rise))
    else $error("Serial output changed away from a rising edge.");

  AST_OUTPUTS_FLOAT: assert property (
    !port_en |-> !serial_data_out_oe && !output_frame_sync_oe)
    else $error("Port outputs driven while disabled.");

  AST_RX_IGNORED: assert property (
    !port_en |=> rx_state == CFS_RX_IDLE && !rx_fresh)
    else $error("Receiver active while disabled.");

  AST_SAMPLE_PERIOD: assert property (
    sample_tick && gap_seen |-> gap_cnt == 16'(GAP - 1))
    else $error("Sample strobe spacing is wrong.");

  AST_DAC_REUSE: assert property (
    sample_tick && !rx_fresh |=> dac_sample == $past(dac_sample, 2) || $past(rx_fresh))
    else $error("Stale sample was not reused.");

  AST_REGS_KEPT: assert property (
    $rose(port_en) |-> control_regs == $past(control_regs) && scnt == '0)
    else $error("Re-enable lost registers or kept timing.");

  AST_SDO_FLOATS_IDLE: assert property (
    tx_state != CFS_TX_SHIFT |-> !serial_data_out_oe)
    else $error("Serial output driven with no word.");

  AST_RX_FRAME_LEN: assert property (
    fall && rx_state == CFS_RX_SHIFT && rx_cnt == 4'hf |=> rx_state == CFS_RX_IDLE)
    else $error("Received frame length is wrong.");
endmodule : cfs_frontend

// ===== verilog/cfs_pkg.sv
// Types shared by the codec serial port front end.
package cfs_pkg;
  typedef enum logic [1:0] {CFS_TX_IDLE, CFS_TX_FSYNC, CFS_TX_SHIFT} cfs_tx_state_t;
  typedef enum logic {CFS_RX_IDLE, CFS_RX_SHIFT} cfs_rx_state_t;
endpackage : cfs_pkg

// ===== verilog/cfs_sync.sv
// Two-stage synchroniser for pin inputs.
module cfs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  // The first stage feeds only the second stage.
  always_comb
  begin
    next_stage1 = reset_n ? din : '0;
    next_dout   = reset_n ? stage1 : '0;
  end

  always_ff @(posedge clk)
  begin
    stage1 <= next_stage1;
    dout   <= next_dout;
  end
endmodule : cfs_sync
